// ---- cbta_top.sv ----
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cbta_top (
  input  wire logic                     clk_sys,      // system clock 100 MHz
  input  wire logic                     rst_b,        // async reset, low
  input  wire logic [3:0]               reg_addr,     // register index
  input  wire logic [7:0]               reg_wdata,    // write data
  input  wire logic                     reg_wr,       // write strobe
  input  wire logic                     reg_rd,       // read strobe
  output logic [7:0]                    reg_rdata,    // read data, next cycle
  input  wire logic                     can_rx,       // bus receive pin
  output logic                          can_tx,       // bus transmit pin
  input  wire logic                     tx_bit,       // bit from frame engine
  input  wire logic                     bus_idle,     // engine idle, allow sync
  input  wire cbta_pkg::cbta_frame_id_t frm_id,       // received identifier
  input  wire logic                     frm_id_valid, // identifier strobe
  output logic                          frm_accept,   // frame kept pulse
  output logic                          frm_reject,   // frame dropped pulse
  output logic [1:0]                    frm_hit,      // pairs that matched
  output logic                          tq_tick,      // quantum pulse
  output logic                          sample_tick,  // sample point pulse
  output logic                          bit_end,      // bit boundary pulse
  output logic                          rx_sample,    // bus level at sample
  output logic                          standby       // cell in standby
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and decode
  logic [7:0]            regs_q [cbta_pkg::CBTA_NREG];
  logic [7:0]            ctrl_q;
  logic [7:0]            reg_rdata_q;
  logic                  wake_seen_q;
  logic                  rej_seen_q;
  logic [1:0]            last_hit_q;
  logic [cbta_pkg::CBTA_NREG-1:0] wr_hit;
  logic                  wr_ctrl;
  logic                  wr_stat;
  logic                  rd_mapped;
  logic [7:0]            rd_mux;
  logic [7:0]            stat_word;

  // one write select per stored register
  for (genvar g = 0; g < cbta_pkg::CBTA_NREG; g++) begin : g_dec
    assign wr_hit[g] = reg_wr && (reg_addr == 4'(g));
  end
  assign wr_ctrl   = reg_wr && (reg_addr == cbta_pkg::CBTA_ADDR_CELL_CONTROL);
  assign wr_stat   = reg_wr && (reg_addr == cbta_pkg::CBTA_ADDR_CELL_STATUS);
  assign rd_mapped = (reg_addr <= cbta_pkg::CBTA_ADDR_CELL_STATUS);

  // stored registers, unwritable bits forced to zero
  for (genvar g = 0; g < cbta_pkg::CBTA_NREG; g++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        regs_q[g] <= cbta_pkg::CBTA_REG_RST;
      end else if (wr_hit[g]) begin
        regs_q[g] <= reg_wdata & cbta_pkg::CBTA_WMASK[g];
      end
    end
  end

  // control register: wake pulse option and standby request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= cbta_pkg::CBTA_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {6'h00, reg_wdata[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views of the registers
  cbta_pkg::cbta_timing_t     timing_cfg;
  cbta_pkg::cbta_accept_set_t set0;
  cbta_pkg::cbta_accept_set_t set1;
  logic                       seg_order_bad;

  // prescale in 5:0, second segment 5:4, first segment 2:0
  assign timing_cfg.quantum_prescale = regs_q[0][cbta_pkg::CBTA_BRP_LSB +: 6];
  assign timing_cfg.bs1 = regs_q[1][cbta_pkg::CBTA_BS1_LSB +: 3];
  assign timing_cfg.bs2 = regs_q[1][cbta_pkg::CBTA_BS2_LSB +: 2];

  // 12-bit words: 8 msbs from high byte, 4 lsbs from upper nibble of low
  assign set0.filt = {regs_q[2], regs_q[3][cbta_pkg::CBTA_FLO_LSB +: 4]};
  assign set0.mask = {regs_q[4], regs_q[5][cbta_pkg::CBTA_FLO_LSB +: 4]};
  assign set1.filt = {regs_q[6], regs_q[7][cbta_pkg::CBTA_FLO_LSB +: 4]};
  assign set1.mask = {regs_q[8], regs_q[9][cbta_pkg::CBTA_FLO_LSB +: 4]};

  // flag when the second segment is at least as long as the first
  assign seg_order_bad = ({1'b0, timing_cfg.bs2} >= timing_cfg.bs1);

  ////////////////////////////////////////////////////////////////////////////
  // bus pin synchroniser and falling edge
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_prev_q;
  logic rx_fall;
  logic restart;
  logic standby_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= can_rx;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  // hard sync on recessive to dominant while idle or asleep
  assign rx_fall = rx_prev_q & ~rx_s2_q;
  assign restart = rx_fall & (bus_idle | standby_q);

  ////////////////////////////////////////////////////////////////////////////
  // bit timing generator and acceptance filter
  logic tq_tick_w;
  logic sample_tick_w;
  logic bit_end_w;

  cbta_timing u_timing (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .cfg_i         (timing_cfg),
    .restart_i     (restart),
    .tq_tick_q     (tq_tick_w),
    .sample_tick_q (sample_tick_w),
    .bit_end_q     (bit_end_w)
  );

  logic       accept_w;
  logic       reject_w;
  logic [1:0] hit_w;

  cbta_filter u_filter (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .id_i     (frm_id),
    .valid_i  (frm_id_valid),
    .set0_i   (set0),
    .set1_i   (set1),
    .accept_q (accept_w),
    .reject_q (reject_w),
    .hit_q    (hit_w)
  );

  assign tq_tick     = tq_tick_w;
  assign sample_tick = sample_tick_w;
  assign bit_end     = bit_end_w;
  assign frm_accept  = accept_w;
  assign frm_reject  = reject_w;
  assign frm_hit     = hit_w;

  ////////////////////////////////////////////////////////////////////////////
  // standby and wake-up pulse sequencer
  cbta_pkg::cbta_state_t state_q;
  cbta_pkg::cbta_state_t state_d;
  logic                  can_tx_q;
  logic                  rx_sample_q;
  logic                  stby_req;
  logic                  wake_en;

  assign stby_req = ctrl_q[cbta_pkg::CBTA_CTRL_STBY];
  assign wake_en  = ctrl_q[cbta_pkg::CBTA_CTRL_WAKE];

  // wait for a bit edge, then hold dominant for one whole bit
  always_comb begin
    state_d = state_q;
    case (state_q)
      cbta_pkg::CBTA_S_RUN: begin
        if (stby_req) begin
          state_d = cbta_pkg::CBTA_S_STBY;
        end
      end
      cbta_pkg::CBTA_S_STBY: begin
        if (!stby_req) begin
          state_d = wake_en ? cbta_pkg::CBTA_S_WAIT : cbta_pkg::CBTA_S_RUN;
        end
      end
      cbta_pkg::CBTA_S_WAIT: begin
        if (bit_end_w) begin
          state_d = cbta_pkg::CBTA_S_PULSE;
        end
      end
      cbta_pkg::CBTA_S_PULSE: begin
        if (bit_end_w) begin
          state_d = cbta_pkg::CBTA_S_RUN;
        end
      end
      default: begin
        state_d = cbta_pkg::CBTA_S_RUN;
      end
    endcase
  end

  // state, pin drive and sampled level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= cbta_pkg::CBTA_S_RUN;
      standby_q   <= 1'b0;
      can_tx_q    <= 1'b1;
      rx_sample_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      standby_q   <= (state_d == cbta_pkg::CBTA_S_STBY);
      can_tx_q    <= (state_d == cbta_pkg::CBTA_S_PULSE) ? 1'b0 :
                     (state_d == cbta_pkg::CBTA_S_RUN) ? tx_bit : 1'b1;
      rx_sample_q <= sample_tick_w ? rx_s2_q : rx_sample_q;
    end
  end

  assign can_tx    = can_tx_q;
  assign standby   = standby_q;
  assign rx_sample = rx_sample_q;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_seen_q <= 1'b0;
      rej_seen_q  <= 1'b0;
      last_hit_q  <= 2'b00;
    end else begin
      wake_seen_q <= (standby_q & rx_fall) |
                     (wake_seen_q & ~(wr_stat & reg_wdata[cbta_pkg::CBTA_STAT_WAKE]));
      rej_seen_q  <= reject_w |
                     (rej_seen_q & ~(wr_stat & reg_wdata[cbta_pkg::CBTA_STAT_REJ]));
      last_hit_q  <= accept_w ? hit_w : last_hit_q;
    end
  end

  // read mux and registered read port
  assign stat_word = {2'b00, last_hit_q, seg_order_bad, rej_seen_q, wake_seen_q, standby_q};
  assign rd_mux    = !rd_mapped ? 8'h00 :
                     (reg_addr == cbta_pkg::CBTA_ADDR_CELL_CONTROL) ? ctrl_q :
                     (reg_addr == cbta_pkg::CBTA_ADDR_CELL_STATUS) ? stat_word :
                     regs_q[reg_addr];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_seg_write;
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == cbta_pkg::CBTA_ADDR_BIT_SEGMENT_TIMING)
      |=> (regs_q[1] == {2'b00, $past(reg_wdata[5:4]), 1'b0, $past(reg_wdata[2:0])});
  endproperty
  a_seg_write: assert property (p_seg_write) else $error("segment fields misplaced");

  property p_prescale_read;
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == cbta_pkg::CBTA_ADDR_BIT_RATE_PRESCALER)
      ##1 (reg_rd && reg_addr == cbta_pkg::CBTA_ADDR_BIT_RATE_PRESCALER && !reg_wr)
      |=> (reg_rdata == {2'b00, $past(reg_wdata[5:0], 2)});
  endproperty
  a_prescale_read: assert property (p_prescale_read) else $error("prescale readback wrong");

  property p_filter_low;
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == cbta_pkg::CBTA_ADDR_ACCEPT_FILTER_LOW1)
      |=> (set1.filt[3:0] == $past(reg_wdata[7:4]) && regs_q[7][3:0] == 4'h0);
  endproperty
  a_filter_low: assert property (p_filter_low) else $error("filter low nibble wrong");

  property p_unmapped;
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_rd && reg_addr > cbta_pkg::CBTA_ADDR_CELL_STATUS) |=> (reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_wake_bit;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_q == cbta_pkg::CBTA_S_WAIT && bit_end_w)
      |=> !can_tx throughout (##[0:1000] bit_end_w);
  endproperty
  a_wake_bit: assert property (p_wake_bit) else $error("wake pulse not dominant");

  property p_no_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_q == cbta_pkg::CBTA_S_STBY && !stby_req && !wake_en)
      |=> (state_q == cbta_pkg::CBTA_S_RUN);
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("wake pulse without option");

  property p_stby_quiet;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_q == cbta_pkg::CBTA_S_STBY) |-> can_tx;
  endproperty
  a_stby_quiet: assert property (p_stby_quiet) else $error("bus driven in standby");

  property p_mask_low;
    @(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == cbta_pkg::CBTA_ADDR_ACCEPT_MASK_LOW_ZERO)
      |=> (set0.mask[3:0] == $past(reg_wdata[7:4]) && regs_q[5][3:0] == 4'h0);
  endproperty
  a_mask_low: assert property (p_mask_low) else $error("mask low nibble wrong");

  property p_reject_sticky;
    @(posedge clk_sys) disable iff (!rst_b)
    frm_reject |=> rej_seen_q;
  endproperty
  a_reject_sticky: assert property (p_reject_sticky) else $error("reject not recorded");

  property p_verdict_once;
    @(posedge clk_sys) disable iff (!rst_b)
    frm_id_valid |=> (frm_accept != frm_reject);
  endproperty
  a_verdict_once: assert property (p_verdict_once) else $error("frame verdict missing");

  c_wake_pulse: cover property (@(posedge clk_sys) disable iff (!rst_b)
                                state_q == cbta_pkg::CBTA_S_PULSE && bit_end_w);
  c_sample:     cover property (@(posedge clk_sys) disable iff (!rst_b)
                                sample_tick_w ##[1:200] bit_end_w);
  c_reject:     cover property (@(posedge clk_sys) disable iff (!rst_b)
                                frm_reject);

endmodule
`default_nettype wire

// ---- cbta_pkg.sv ----
`default_nettype none
package cbta_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int unsigned CBTA_AW   = 4;
  localparam int unsigned CBTA_DW   = 8;
  localparam int unsigned CBTA_NREG = 10;

  // register indices, byte address equals index
  localparam logic [3:0] CBTA_ADDR_BIT_RATE_PRESCALER    = 4'h0;
  localparam logic [3:0] CBTA_ADDR_BIT_SEGMENT_TIMING    = 4'h1;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_FILTER_HIGH0   = 4'h2;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_FILTER_LOW0    = 4'h3;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_MASK_HIGH_ZERO = 4'h4;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_MASK_LOW_ZERO  = 4'h5;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_FILTER_HIGH1   = 4'h6;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_FILTER_LOW1    = 4'h7;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_MASK_HIGH_ONE  = 4'h8;
  localparam logic [3:0] CBTA_ADDR_ACCEPT_MASK_LOW_ONE   = 4'h9;
  localparam logic [3:0] CBTA_ADDR_CELL_CONTROL         = 4'hA;
  localparam logic [3:0] CBTA_ADDR_CELL_STATUS          = 4'hB;

  // writable bits of each stored register, by index
  localparam logic [CBTA_NREG-1:0][7:0] CBTA_WMASK = {
    8'hF0, 8'hFF, 8'hF0, 8'hFF, 8'hF0, 8'hFF, 8'hF0, 8'hFF, 8'h37, 8'h3F
  };
  localparam logic [7:0] CBTA_REG_RST  = 8'h00;
  localparam logic [7:0] CBTA_CTRL_RST = 8'h00;

  // field positions
  localparam int unsigned CBTA_BRP_LSB     = 0;
  localparam int unsigned CBTA_BS1_LSB     = 0;
  localparam int unsigned CBTA_BS2_LSB     = 4;
  localparam int unsigned CBTA_FLO_LSB     = 4;
  localparam int unsigned CBTA_CTRL_WAKE   = 0;
  localparam int unsigned CBTA_CTRL_STBY   = 1;
  localparam int unsigned CBTA_STAT_STBY   = 0;
  localparam int unsigned CBTA_STAT_WAKE   = 1;
  localparam int unsigned CBTA_STAT_REJ    = 2;
  localparam int unsigned CBTA_STAT_SEGBAD = 3;
  localparam int unsigned CBTA_STAT_HIT    = 4;

  // fixed part of a bit: sync quantum plus the two +1 offsets
  localparam logic [4:0] CBTA_BIT_FIXED_TQ = 5'h03;
  localparam logic [4:0] CBTA_SAMPLE_OFS   = 5'h02;

  // bit timing configuration
  typedef struct packed {
    logic [5:0] quantum_prescale;
    logic [2:0] bs1;
    logic [1:0] bs2;
  } cbta_timing_t;

  // received identifier and frame type, frame type in the lsb
  typedef struct packed {
    logic [10:0] ident;
    logic        rtr;
  } cbta_frame_id_t;

  // one filter/mask pair
  typedef struct packed {
    logic [11:0] filt;
    logic [11:0] mask;
  } cbta_accept_set_t;

  typedef enum logic [1:0] {
    CBTA_S_RUN   = 2'b00,
    CBTA_S_STBY  = 2'b01,
    CBTA_S_WAIT  = 2'b10,
    CBTA_S_PULSE = 2'b11
  } cbta_state_t;

endpackage
`default_nettype wire

// ---- cbta_timing.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbta_timing (
  input  wire logic                  clk_sys,       // system clock
  input  wire logic                  rst_b,         // async reset, low
  input  wire cbta_pkg::cbta_timing_t cfg_i,        // programmed timing
  input  wire logic                  restart_i,     // hard sync, restart bit
  output logic                       tq_tick_q,     // one quantum done
  output logic                       sample_tick_q, // sample point
  output logic                       bit_end_q      // bit boundary
);

  ////////////////////////////////////////////////////////////////////////////
  // counters and shadow of the configuration
  cbta_pkg::cbta_timing_t cfg_q;
  logic [5:0]             presc_q;
  logic [3:0]             tqn_q;
  logic                   tq;
  logic                   tq_last;
  logic                   at_sample;
  logic [3:0]             last_tq;

  // quantum ends after brp+1 clocks, bit after 3+bs1+bs2 quanta
  assign tq        = (presc_q == cfg_q.quantum_prescale);
  assign last_tq   = 4'({1'b0, cfg_q.bs1}) + 4'({2'b00, cfg_q.bs2}) + 4'h2;
  assign tq_last   = (tqn_q == last_tq);
  assign at_sample = (tqn_q == 4'({1'b0, cfg_q.bs1}) + 4'h1);

  // prescaler, quantum index, shadow reloaded at bit edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= 6'h00;
      tqn_q   <= 4'h0;
      cfg_q   <= '0;
    end else if (restart_i) begin
      presc_q <= 6'h00;
      tqn_q   <= 4'h0;
      cfg_q   <= cfg_i;
    end else begin
      presc_q <= tq ? 6'h00 : presc_q + 6'h01;
      if (tq) begin
        tqn_q <= tq_last ? 4'h0 : tqn_q + 4'h1;
      end
      if (tq && tq_last) begin
        cfg_q <= cfg_i;
      end
    end
  end

  // registered tick outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tq_tick_q     <= 1'b0;
      sample_tick_q <= 1'b0;
      bit_end_q     <= 1'b0;
    end else begin
      tq_tick_q     <= tq & ~restart_i;
      sample_tick_q <= tq & at_sample & ~restart_i;
      bit_end_q     <= tq & tq_last & ~restart_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers: clocks since last quantum, quanta since bit edge
  logic [6:0] gap_q;
  logic [3:0] tqs_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 7'h7F; // as after restart, first tick wraps to 0
      tqs_q <= 4'h0;
    end else begin
      gap_q <= restart_i ? 7'h7F : (tq_tick_q ? 7'h00 : gap_q + 7'h01);
      tqs_q <= (restart_i | bit_end_q) ? 4'h0 : (tq_tick_q ? tqs_q + 4'h1 : tqs_q);
    end
  end

  property p_tq_period;
    @(posedge clk_sys) disable iff (!rst_b)
    (tq_tick_q && !$past(restart_i)) |-> (gap_q == 7'($past(cfg_q.quantum_prescale)));
  endproperty
  a_tq_period: assert property (p_tq_period) else $error("quantum length wrong");

  property p_bit_len;
    @(posedge clk_sys) disable iff (!rst_b)
    bit_end_q |-> (5'(tqs_q) + 5'h01 == 5'($past(cfg_q.bs1)) + 5'($past(cfg_q.bs2))
                   + cbta_pkg::CBTA_BIT_FIXED_TQ);
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit length wrong");

  property p_sample_pos;
    @(posedge clk_sys) disable iff (!rst_b)
    sample_tick_q |-> (5'(tqs_q) + 5'h01 == 5'(cfg_q.bs1) + cbta_pkg::CBTA_SAMPLE_OFS);
  endproperty
  a_sample_pos: assert property (p_sample_pos) else $error("sample point misplaced");

endmodule
`default_nettype wire

// ---- cbta_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbta_filter (
  input  wire logic                      clk_sys,  // system clock
  input  wire logic                      rst_b,    // async reset, low
  input  wire cbta_pkg::cbta_frame_id_t  id_i,     // identifier and type
  input  wire logic                      valid_i,  // identifier strobe
  input  wire cbta_pkg::cbta_accept_set_t set0_i,  // pair zero
  input  wire cbta_pkg::cbta_accept_set_t set1_i,  // pair one
  output logic                           accept_q, // frame kept
  output logic                           reject_q, // frame dropped
  output logic [1:0]                     hit_q     // matching pairs
);

  ////////////////////////////////////////////////////////////////////////////
  // per pair compare over 12 bits, mask one means must match
  cbta_pkg::cbta_accept_set_t sets [2];
  logic [1:0]                 hit;
  assign sets[0] = set0_i;
  assign sets[1] = set1_i;

  for (genvar g = 0; g < 2; g++) begin : g_pair
    assign hit[g] = ~|((id_i ^ sets[g].filt) & sets[g].mask);
  end

  // either pair accepts, else discard
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      accept_q <= 1'b0;
      reject_q <= 1'b0;
      hit_q    <= 2'b00;
    end else begin
      accept_q <= valid_i & (|hit);
      reject_q <= valid_i & ~(|hit);
      hit_q    <= valid_i ? hit : hit_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_accept;
    @(posedge clk_sys) disable iff (!rst_b)
    (valid_i && (((id_i ^ set0_i.filt) & set0_i.mask) == 12'h000
              || ((id_i ^ set1_i.filt) & set1_i.mask) == 12'h000))
      |=> (accept_q && !reject_q);
  endproperty
  a_accept: assert property (p_accept) else $error("matching frame not accepted");

  property p_reject;
    @(posedge clk_sys) disable iff (!rst_b)
    (valid_i && ((id_i ^ set0_i.filt) & set0_i.mask) != 12'h000
             && ((id_i ^ set1_i.filt) & set1_i.mask) != 12'h000)
      |=> (reject_q && !accept_q);
  endproperty
  a_reject: assert property (p_reject) else $error("non matching frame accepted");

  property p_type_dontcare;
    @(posedge clk_sys) disable iff (!rst_b)
    (valid_i && !set0_i.mask[0]
             && (((id_i ^ set0_i.filt) & set0_i.mask) & 12'hFFE) == 12'h000)
      |=> (accept_q && hit_q[0]);
  endproperty
  a_type_dontcare: assert property (p_type_dontcare) else $error("type bit not ignored");

  c_accept_one: cover property (@(posedge clk_sys) disable iff (!rst_b)
                                accept_q && hit_q == 2'b10);

endmodule
`default_nettype wire

// ---- cbta_node_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbta_node_model (
  input  wire logic clk_sys,  // system clock
  input  wire logic dom_req,  // drive dominant while high
  output logic      can_line  // bus level, 1 recessive
);
  // released bus floats back to recessive through the termination
  initial can_line = 1'b1;
  always @(posedge clk_sys) begin
    can_line <= !dom_req;
  end
endmodule
`default_nettype wire

// ---- cbta_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbta_top_tb;
  logic                     clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, vld = 0, dom = 0;
  logic [3:0]               reg_addr = 0;
  logic [7:0]               reg_wdata = 0, rdat;
  logic                     can_rx, can_tx, acc, rej, tq, smp, bend, rxs, stby;
  logic [1:0]               hit;
  cbta_pkg::cbta_frame_id_t fid = '0;
  int                       miscompares = 0, total_checks = 0, cyc = 0, n;
  // pair words: remote/data group of four ids and a data-only group of 64 ids
  localparam logic [3:0][11:0] W = {12'hA93, 12'h202, 12'h9FE, 12'h800};
  always #5 clk_sys = ~clk_sys;
  cbta_node_model node (.clk_sys(clk_sys), .dom_req(dom), .can_line(can_rx));
  cbta_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat), .can_rx(can_rx), .can_tx(can_tx),
    .tx_bit(1'b1), .bus_idle(1'b0), .frm_id(fid), .frm_id_valid(vld), .frm_accept(acc),
    .frm_reject(rej), .frm_hit(hit), .tq_tick(tq), .sample_tick(smp), .bit_end(bend),
    .rx_sample(rxs), .standby(stby));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(rdat & m, e);
  endtask
  // write then read with no gap between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_sys);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0; reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(rdat, e);
  endtask
  // identifier in, expected verdict from the pair words
  task automatic frame(input logic [10:0] id, input logic rtr);
    logic m0, m1;
    m0 = (({id, rtr} ^ W[0]) & W[1]) == 12'h000;
    m1 = (({id, rtr} ^ W[2]) & W[3]) == 12'h000;
    @(posedge clk_sys);
    fid <= {id, rtr}; vld <= 1;
    @(posedge clk_sys);
    vld <= 0;
    #1 chk({acc, rej, hit}, {m0 | m1, !(m0 | m1), m1, m0});
  endtask
  // cycles until the chosen timing pulse
  task automatic gap(input int w, output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (!(w == 0 ? tq : w == 1 ? bend : smp));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, whole run is well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1;
    for (int a = 0; a < 13; a++) rd(a[3:0], 8'hFF, a == 11 ? 8'h08 : 8'h00);
    for (int a = 0; a < 10; a++) begin
      wr(a[3:0], 8'hFF);
      rd(a[3:0], 8'hFF, a == 0 ? 8'h3F : a == 1 ? 8'h37 : a[0] ? 8'hF0 : 8'hFF);
    end
    wr(4'hC, 8'hFF);
    rd(4'hC, 8'hFF, 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(4'(2 + 2 * g), W[g][11:4]);
      wr(4'(3 + 2 * g), {W[g][3:0], 4'h0});
    end
    frame(11'h500, 1);
    frame(11'h600, 0);
    frame(11'h127, 0);
    frame(11'h501, 0);
    frame(11'h3A5, 1);
    wr_rd(4'h0, 8'h03, 8'h03);
    wr(4'h1, 8'h23);
    repeat (3) gap(1, n);
    gap(1, n); chk(n, 32);
    gap(0, n); chk(n, 4);
    gap(2, n); gap(1, n); chk(n, 12);
    // bus level captured at the sample point
    dom <= 1;
    repeat (2) gap(2, n);
    @(posedge clk_sys);
    #1 chk(rxs, 0);
    dom <= 0;
    repeat (2) gap(2, n);
    @(posedge clk_sys);
    #1 chk(rxs, 1);
    wr(4'hA, 8'h03);
    dom <= 1;
    repeat (10) @(posedge clk_sys);
    dom <= 0;
    rd(4'hB, 8'h03, 8'h03);
    wr(4'hA, 8'h01);
    n = 0;
    repeat (120) begin
      @(posedge clk_sys);
      #1 n += !can_tx;
    end
    chk(n, 32);
    chk(stby, 0);
    rd(4'hB, 8'hFF, 8'h26);
    wr(4'hB, 8'h06);
    rd(4'hB, 8'hFF, 8'h20);
    // leave standby without the wake option: no pulse
    wr(4'hA, 8'h02);
    wr(4'hA, 8'h00);
    rd(4'hB, 8'h01, 8'h00);
    chk(can_tx, 1);
    complete_run();
  end
endmodule
`default_nettype wire
